// file: sim/wwr_spi_master.sv
// Serial master model standing in for the microcontroller on the link.
// Assumes the core clock of the bench; link clock is 8 core cycles.
`timescale 1ns/1ps
`default_nettype none
module wwr_spi_master (
  input wire logic clk,
  input wire logic spi_do,
  output logic csn_b,
  output logic sclk,
  output logic di
);
  initial begin
    csn_b = 1'b1;
    sclk = 1'b0;
    di = 1'b0;
  end

  // One full 16-bit frame, MSB first; link clock idles low between frames
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    r = 16'h0000;
    @(posedge clk);
    csn_b <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      di <= w[15-i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
      r = {r[14:0], spi_do};
      repeat (2) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    csn_b <= 1'b1;
    // Released data line shows the inverse, never a stale level
    di <= ~di;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: sim/wwr_watchdog_tb_top.sv
// Self-checking bench for the watchdog, reset and diagnostic block.
// Assumes the serial master model drives the link; ticks shortened to 10 clocks.
`timescale 1ns/1ps
`default_nettype none
module wwr_watchdog_tb_top;
  import wwr_pkg::*;
  localparam int TK = 10;
  localparam int HF = 4 * int'(WD_HALF_STEP_MS) * TK;
  localparam int SD = int'(RST_DLY_SHORT_MS) * TK;
  localparam int LD = int'(RST_DLY_LONG_MS) * TK;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  wwr_diag_s dg = '0;
  logic csn_b, sclk, di, spi_do, rxd_low, reset_out_b, lamp_on, supply_on;
  logic [1:0] ls_on;
  wwr_mode_e mode;
  wwr_wd_e wd_state;
  logic [15:0] rd;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0;

  always #50 clk = ~clk;

  wwr_watchdog #(.TICK_CYC_P(TK)) u_wwr_watchdog (
    .clk(clk), .rst_b(rst_b), .diag_in(dg), .spi_csn_b(csn_b), .spi_sclk(sclk),
    .spi_di(di), .spi_do(spi_do), .rxd_low(rxd_low), .reset_out_b(reset_out_b),
    .lamp_on(lamp_on), .ls_on(ls_on), .supply_on(supply_on), .mode(mode),
    .wd_state(wd_state));
  wwr_spi_master u_wwr_spi_master (
    .clk(clk), .spi_do(spi_do), .csn_b(csn_b), .sclk(sclk), .di(di));

  task automatic close_out();
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic inr(input int d, input int e);
    // Tick phase and sync delay both shift the start point by up to one tick
    return (d > e - 2 * TK) && (d < e + 2 * TK);
  endfunction

  function automatic logic [15:0] wdw(input logic sh, input logic lp, input logic [5:0] p);
    return {SEL_WD, 6'h00, sh, lp, p};
  endfunction

  // Low field: mode, lamp off on battery fault, supply, relays, lamp
  function automatic logic [15:0] cfgw(input logic [6:0] f);
    return {SEL_CFG, 7'h00, f};
  endfunction

  task automatic x(input logic [15:0] w);
    u_wwr_spi_master.xfer(w, rd);
    @(negedge clk);
  endtask

  task automatic pulse(input wwr_diag_s m, input int k);
    @(posedge clk);
    dg <= wwr_diag_s'(dg | m);
    repeat (k) @(posedge clk);
    dg <= wwr_diag_s'(dg & ~m);
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wait_wd(input wwr_wd_e st);
    int n = 0;
    while (wd_state !== st && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wait_rst();
    int n = 0;
    while (reset_out_b !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic s_reset();
    @(negedge clk);
    chk(16'(reset_out_b), 16'h0000);
    t0 = cyc;
    wait_rst();
    chk(16'(inr(cyc - t0, LD)), 16'h0001);
    chk(16'(wd_state), 16'(WD_LONG));
    chk(16'(mode), 16'(MD_STANDBY));
  endtask

  task automatic s_window();
    x(wdw(1'b1, 1'b0, 6'h04));
    t0 = cyc;
    chk(16'(wd_state), 16'(WD_CLOSED));
    x(cfgw(7'h2f));
    chk(16'(mode), 16'(MD_ACTIVE));
    chk(16'(wd_state), 16'(WD_CLOSED));
    wait_wd(WD_OPEN);
    chk(16'(inr(cyc - t0, HF)), 16'h0001);
    x(wdw(1'b1, 1'b0, 6'h04));
    chk(16'({reset_out_b, wd_state}), 16'(5'h12));
  endtask

  task automatic s_early();
    x(wdw(1'b1, 1'b0, 6'h04));
    t0 = cyc;
    chk(16'({reset_out_b, wd_state}), 16'(5'h01));
    chk(16'(mode), 16'(MD_STANDBY));
    chk(16'({lamp_on, ls_on, supply_on}), 16'h0000);
    wait_rst();
    chk(16'(inr(cyc - t0, SD)), 16'h0001);
    x(cfgw(7'h00));
    chk(16'(rd[ST_WD]), 16'h0001);
    x(cfgw(7'h00));
    chk(16'(rd[ST_WD]), 16'h0000);
    x(wdw(1'b1, 1'b0, 6'h3f));
  endtask

  task automatic s_lamp();
    x(cfgw(7'h21));
    chk(16'(lamp_on), 16'h0001);
    pulse('{lamp_fault: 1'b1, default: '0}, 5);
    chk(16'(lamp_on), 16'h0000);
    x(cfgw(7'h21));
    chk(16'({rd[ST_LAMP], rd[ST_VINT], lamp_on}), 16'h0007);
    pulse('{vbat_uv: 1'b1, vs_uv: 1'b1, default: '0}, 5);
    chk(16'(lamp_on), 16'h0001);
    @(posedge clk);
    dg.lin_txd_to <= 1'b1;
    x(cfgw(7'h31));
    chk(16'({rd[ST_VB_UV], rd[ST_VS_UV], rd[ST_LIN]}), 16'h0007);
    @(posedge clk);
    dg.lin_txd_to <= 1'b0;
    x(cfgw(7'h31));
    chk(16'(rd[ST_VS_UV]), 16'h0000);
    pulse('{vbat_ov: 1'b1, default: '0}, 5);
    chk(16'(lamp_on), 16'h0000);
  endtask

  task automatic s_vcc();
    pulse('{vcc_uv: 1'b1, default: '0}, FILTER_CYC / 2);
    chk(16'(reset_out_b), 16'h0001);
    pulse('{vcc_uv: 1'b1, default: '0}, FILTER_CYC + 10);
    t0 = cyc;
    chk(16'({reset_out_b, wd_state}), 16'(5'h01));
    wait_rst();
    chk(16'(inr(cyc - t0, SD)), 16'h0001);
  endtask

  task automatic s_wake();
    x(cfgw(7'h60));
    pulse('{lin_wake: 1'b1, default: '0}, 5);
    chk(16'({rxd_low, spi_do}), 16'h0002);
    chk(16'(mode), 16'(MD_STANDBY));
    x(cfgw(7'h60));
    chk(16'(rd[ST_LIN]), 16'h0001);
    pulse('{mon_wake: 5'h04, default: '0}, 5);
    chk(16'(spi_do), 16'h0000);
    x(cfgw(7'h00));
    chk(16'(rd[ST_MON_LO+:5]), 16'h0004);
  endtask

  task automatic s_misc();
    @(posedge clk);
    dg.spi_fail <= 1'b1;
    x(16'h0000);
    chk(rd, 16'hffff);
    @(posedge clk);
    dg <= '{vcc_i_low: 1'b1, default: '0};
    x(cfgw(7'h40));
    chk(16'({mode, wd_state}), 16'h0048);
    @(posedge clk);
    dg.vcc_i_low <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(16'(wd_state !== WD_OFF), 16'h0001);
  endtask

  task automatic s_vint();
    x(cfgw(7'h2f));
    chk(16'({lamp_on, ls_on, supply_on}), 16'h000f);
    pulse('{vint_uv: 1'b1, default: '0}, 5);
    t0 = cyc;
    chk(16'({reset_out_b, lamp_on, ls_on, supply_on}), 16'h0000);
    chk(16'({mode, wd_state}), 16'h0011);
    wait_rst();
    chk(16'(inr(cyc - t0, LD)), 16'h0001);
    x(cfgw(7'h00));
    chk(16'(rd[ST_VINT]), 16'h0000);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    s_reset();
    s_window();
    s_early();
    s_lamp();
    s_vcc();
    s_wake();
    s_misc();
    s_vint();
    close_out();
  end
endmodule
`default_nettype wire

// file: verilog/wwr_pkg.sv
// Constants, types and word layouts for the window watchdog, reset and diagnostic block.
// Assumes a 10 MHz core clock and a 16-bit serial word, most significant bit first.
package wwr_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned FILTER_US = 10;
  localparam int unsigned FILTER_CYC = (FILTER_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned MS_W = 10;
  localparam logic [MS_W-1:0] WD_HALF_STEP_MS = 10'h008;
  localparam logic [MS_W-1:0] LONG_OPEN_MS = 10'h0c8;
  localparam logic [MS_W-1:0] RST_DLY_LONG_MS = 10'h040;
  localparam logic [MS_W-1:0] RST_DLY_SHORT_MS = 10'h004;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned SEL_LO = 14;
  localparam logic [1:0] SEL_CFG = 2'h0;
  localparam logic [1:0] SEL_WD = 2'h1;
  localparam int unsigned WD_PER_LO = 0;
  localparam int unsigned WD_PER_W = 6;
  localparam int unsigned WD_LP_EN_BIT = 6;
  localparam int unsigned RST_SHORT_BIT = 7;
  localparam int unsigned CFG_LAMP_BIT = 0;
  localparam int unsigned CFG_LS_LO = 1;
  localparam int unsigned CFG_SUP_BIT = 3;
  localparam int unsigned CFG_VB_OFF_BIT = 4;
  localparam int unsigned CFG_MODE_LO = 5;
  localparam int unsigned ST_TEMP = 0;
  localparam int unsigned ST_LAMP = 1;
  localparam int unsigned ST_VINT = 2;
  localparam int unsigned ST_LS = 3;
  localparam int unsigned ST_WD = 4;
  localparam int unsigned ST_MON_LO = 5;
  localparam int unsigned ST_LIN = 11;
  localparam int unsigned ST_VB_UV = 12;
  localparam int unsigned ST_VB_OV = 13;
  localparam int unsigned ST_SUP = 14;
  localparam int unsigned ST_VS_UV = 15;
  localparam logic [WORD_W-1:0] STAT_RST = 16'h0000;

  typedef enum logic [3:0] {
    WD_LONG = 4'h1, WD_CLOSED = 4'h2, WD_OPEN = 4'h4, WD_OFF = 4'h8
  } wwr_wd_e;
  typedef enum logic [3:0] {
    MD_STANDBY = 4'h1, MD_ACTIVE = 4'h2, MD_STOP = 4'h4, MD_SLEEP = 4'h8
  } wwr_mode_e;
  typedef enum logic [2:0] {RS_LOW = 3'h1, RS_DELAY = 3'h2, RS_HIGH = 3'h4} wwr_rst_e;

  typedef struct packed {
    logic temp_warn;
    logic lamp_fault;
    logic ls_fault;
    logic sup_fault;
    logic vbat_uv;
    logic vbat_ov;
    logic vs_uv;
    logic lin_ot;
    logic lin_uv;
    logic lin_txd_to;
    logic lin_wake;
    logic [4:0] mon_wake;
    logic [4:0] mon_lvl;
    logic vcc_uv;
    logic vint_uv;
    logic vcc_i_low;
    logic spi_fail;
  } wwr_diag_s;
endpackage

// file: verilog/wwr_watchdog.sv
// Window watchdog, reset generator and latched diagnostics behind a serial slave.
// Assumes all diagnostic flags and serial pins arrive from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module wwr_watchdog
  import wwr_pkg::*;
#(
  parameter int unsigned TICK_CYC_P = TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire wwr_diag_s diag_in,
  input wire logic spi_csn_b,
  input wire logic spi_sclk,
  input wire logic spi_di,
  output logic spi_do,
  output logic rxd_low,
  output logic reset_out_b,
  output logic lamp_on,
  output logic [1:0] ls_on,
  output logic supply_on,
  output wwr_mode_e mode,
  output wwr_wd_e wd_state
);
  logic [1:0] rsync_q;
  logic rst_n;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsync_q <= 2'h0;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  // Two-stage synchronisers, plus a third copy for edge detection
  wwr_diag_s d1_q, s;
  logic [2:0] p1_q, p2_q, p3_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d1_q <= '0;
      s <= '0;
      p1_q <= 3'h1;
      p2_q <= 3'h1;
      p3_q <= 3'h1;
    end else begin
      d1_q <= diag_in;
      s <= d1_q;
      p1_q <= {spi_di, spi_sclk, spi_csn_b};
      p2_q <= p1_q;
      p3_q <= p2_q;
    end
  end
  logic csn, sclk_rise, sclk_fall, frame_start, frame_end;
  assign csn = p2_q[0];
  assign sclk_rise = p2_q[1] & ~p3_q[1];
  assign sclk_fall = ~p2_q[1] & p3_q[1];
  assign frame_start = ~p2_q[0] & p3_q[0];
  assign frame_end = p2_q[0] & ~p3_q[0];

  // Millisecond enable
  logic [13:0] tick_cnt_q, tick_cnt_d;
  logic tick;
  assign tick = tick_cnt_q == 14'(TICK_CYC_P - 1);
  always_comb begin
    tick_cnt_d = tick ? 14'h0000 : tick_cnt_q + 14'h0001;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 14'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // Serial shift logic
  logic [WORD_W-1:0] sh_in_q, sh_in_d, sh_out_q, sh_out_d, stat_q, snap;
  logic [4:0] bits_q, bits_d;
  logic do_q, do_d, wake_q, wake_d, linw_q, linw_d;
  logic frame_ok, sel_wd, sel_cfg;
  assign frame_ok = frame_end && bits_q == 5'h10;
  assign sel_wd = frame_ok && sh_in_q[WORD_W-1:SEL_LO] == SEL_WD;
  assign sel_cfg = frame_ok && sh_in_q[WORD_W-1:SEL_LO] == SEL_CFG;
  always_comb begin
    sh_in_d = sh_in_q;
    sh_out_d = sh_out_q;
    bits_d = bits_q;
    if (frame_start) begin
      sh_out_d = snap;
      bits_d = 5'h00;
    end else if (!csn && sclk_rise) begin
      sh_in_d = {sh_in_q[WORD_W-2:0], p2_q[2]};
      bits_d = (bits_q == 5'h1f) ? bits_q : bits_q + 5'h01;
    end else if (!csn && sclk_fall) begin
      sh_out_d = {sh_out_q[WORD_W-2:0], 1'b0};
    end
    wake_d = (wake_q & ~frame_end) | s.lin_wake | (|s.mon_wake);
    linw_d = (linw_q & ~frame_end) | s.lin_wake;
    if (csn) begin
      do_d = ~wake_q;
    end else if (s.spi_fail) begin
      do_d = 1'b1;
    end else begin
      do_d = sh_out_q[WORD_W-1];
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_in_q <= '0;
      sh_out_q <= '0;
      bits_q <= 5'h00;
      do_q <= 1'b1;
      wake_q <= 1'b0;
      linw_q <= 1'b0;
    end else begin
      sh_in_q <= sh_in_d;
      sh_out_q <= sh_out_d;
      bits_q <= bits_d;
      do_q <= do_d;
      wake_q <= wake_d;
      linw_q <= linw_d;
    end
  end

  // Reset generator
  wwr_rst_e rs_q, rs_d;
  logic [6:0] filt_q, filt_d;
  logic [MS_W-1:0] dly_q, dly_d;
  logic rout_q, rout_d, short_q, wd_fail, vcc_fail;
  assign vcc_fail = filt_q == 7'(FILTER_CYC);
  always_comb begin
    filt_d = !s.vcc_uv ? 7'h00 : vcc_fail ? filt_q : filt_q + 7'h01;
    rs_d = rs_q;
    dly_d = dly_q;
    if (s.vint_uv || vcc_fail || wd_fail) begin
      rs_d = RS_LOW;
      dly_d = '0;
    end else begin
      case (rs_q)
        RS_LOW: rs_d = RS_DELAY;
        RS_DELAY: begin
          if (tick) begin
            dly_d = dly_q + 10'h001;
          end
          if (dly_q >= (short_q ? RST_DLY_SHORT_MS : RST_DLY_LONG_MS)) begin
            rs_d = RS_HIGH;
          end
        end
        RS_HIGH: rs_d = RS_HIGH;
        default: rs_d = RS_LOW;
      endcase
    end
    rout_d = rs_d == RS_HIGH;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_q <= RS_LOW;
      filt_q <= 7'h00;
      dly_q <= '0;
      rout_q <= 1'b0;
    end else begin
      rs_q <= rs_d;
      filt_q <= filt_d;
      dly_q <= dly_d;
      rout_q <= rout_d;
    end
  end

  // Window watchdog
  wwr_wd_e wd_q, wd_d;
  wwr_mode_e mode_q, mode_d;
  logic [MS_W-1:0] wcnt_q, wcnt_d, half_q, half_d;
  logic [WD_PER_W-1:0] per;
  logic lp_en_q, wd_off;
  assign per = sh_in_q[WD_PER_LO+:WD_PER_W];
  assign wd_off = ((mode_q == MD_STOP) && s.vcc_i_low || (mode_q == MD_SLEEP)) && !lp_en_q;
  always_comb begin
    wd_d = wd_q;
    wcnt_d = tick ? wcnt_q + 10'h001 : wcnt_q;
    half_d = half_q;
    wd_fail = 1'b0;
    if (!rout_q) begin
      wd_d = WD_LONG;
      wcnt_d = '0;
    end else if (wd_off) begin
      wd_d = WD_OFF;
      wcnt_d = '0;
    end else begin
      case (wd_q)
        WD_OFF: begin
          wd_d = WD_LONG;
          wcnt_d = '0;
        end
        WD_LONG, WD_OPEN: begin
          if (sel_wd) begin
            wd_d = WD_CLOSED;
            wcnt_d = '0;
            half_d = 10'(per == '0 ? 6'h01 : per) * WD_HALF_STEP_MS;
          end else if (wcnt_q >= (wd_q == WD_LONG ? LONG_OPEN_MS : half_q)) begin
            wd_fail = 1'b1;
            wd_d = WD_LONG;
            wcnt_d = '0;
          end
        end
        WD_CLOSED: begin
          if (sel_wd) begin
            wd_fail = 1'b1;
            wd_d = WD_LONG;
            wcnt_d = '0;
          end else if (wcnt_q >= half_q) begin
            wd_d = WD_OPEN;
            wcnt_d = '0;
          end
        end
        default: wd_d = WD_LONG;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_q <= WD_LONG;
      wcnt_q <= '0;
      half_q <= WD_HALF_STEP_MS;
    end else begin
      wd_q <= wd_d;
      wcnt_q <= wcnt_d;
      half_q <= half_d;
    end
  end

  // Configuration, switches and status latches
  logic lamp_q, lamp_d, sup_q, sup_d, vboff_q, vboff_d, lp_en_d, short_d;
  logic [1:0] ls_q, ls_d;
  logic [WORD_W-1:0] stat_d, st_set;
  logic low_pwr;
  assign low_pwr = mode_q == MD_STOP || mode_q == MD_SLEEP;
  assign snap = stat_q | (stat_q[ST_MON_LO+:5] == 5'h00 && !low_pwr ?
                          WORD_W'({s.mon_lvl, 5'h00}) : '0);
  always_comb begin
    lamp_d = lamp_q;
    ls_d = ls_q;
    sup_d = sup_q;
    vboff_d = vboff_q;
    lp_en_d = lp_en_q;
    short_d = short_q;
    mode_d = mode_q;
    st_set = '0;
    st_set[ST_TEMP] = s.temp_warn;
    st_set[ST_LAMP] = s.lamp_fault;
    st_set[ST_LS] = s.ls_fault;
    st_set[ST_WD] = wd_fail;
    st_set[ST_MON_LO+:5] = low_pwr ? s.mon_wake : 5'h00;
    st_set[ST_LIN] = s.lin_ot | s.lin_uv | s.lin_txd_to | s.lin_wake;
    st_set[ST_VB_UV] = s.vbat_uv;
    st_set[ST_VB_OV] = s.vbat_ov;
    st_set[ST_SUP] = s.sup_fault;
    st_set[ST_VS_UV] = s.vs_uv;
    // Reads clear the latches except ST_VINT, a coinciding event still sets
    stat_d = (stat_q & ~(frame_end ? ~WORD_W'(1 << ST_VINT) : '0)) | st_set;
    if (sel_cfg) begin
      lamp_d = sh_in_q[CFG_LAMP_BIT];
      ls_d = sh_in_q[CFG_LS_LO+:2];
      sup_d = sh_in_q[CFG_SUP_BIT];
      vboff_d = sh_in_q[CFG_VB_OFF_BIT];
      stat_d[ST_VINT] = 1'b1;
      case (sh_in_q[CFG_MODE_LO+:2])
        2'h0: mode_d = MD_STANDBY;
        2'h1: mode_d = MD_ACTIVE;
        2'h2: mode_d = MD_STOP;
        default: mode_d = MD_SLEEP;
      endcase
    end
    if (sel_wd) begin
      lp_en_d = sh_in_q[WD_LP_EN_BIT];
      short_d = sh_in_q[RST_SHORT_BIT];
    end
    if (low_pwr && (s.lin_wake || |s.mon_wake)) begin
      mode_d = MD_STANDBY;
    end
    if (mode_d == MD_STOP || mode_d == MD_SLEEP) begin
      lamp_d = 1'b0;
    end
    if (s.lamp_fault || (vboff_q && (s.vbat_uv || s.vbat_ov))) begin
      lamp_d = 1'b0;
    end
    if (s.ls_fault) begin
      ls_d = 2'h0;
    end
    if (s.sup_fault) begin
      sup_d = 1'b0;
    end
    if (!rout_d || wd_fail) begin
      mode_d = MD_STANDBY;
      lamp_d = 1'b0;
      ls_d = 2'h0;
      sup_d = 1'b0;
    end
    if (s.vint_uv) begin
      vboff_d = 1'b0;
      lp_en_d = 1'b0;
      short_d = 1'b0;
      stat_d[ST_VINT] = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lamp_q <= 1'b0;
      ls_q <= 2'h0;
      sup_q <= 1'b0;
      vboff_q <= 1'b0;
      lp_en_q <= 1'b0;
      short_q <= 1'b0;
      mode_q <= MD_STANDBY;
      stat_q <= STAT_RST;
    end else begin
      lamp_q <= lamp_d;
      ls_q <= ls_d;
      sup_q <= sup_d;
      vboff_q <= vboff_d;
      lp_en_q <= lp_en_d;
      short_q <= short_d;
      mode_q <= mode_d;
      stat_q <= stat_d;
    end
  end

  assign spi_do = do_q;
  assign rxd_low = linw_q;
  assign reset_out_b = rout_q;
  assign lamp_on = lamp_q;
  assign ls_on = ls_q;
  assign supply_on = sup_q;
  assign mode = mode_q;
  assign wd_state = wd_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  lamp_fault_off_a: assert property (s.lamp_fault |=> !lamp_q && stat_q[ST_LAMP])
    else $error("lamp driver left on after fault");
  vbat_latch_a: assert property (s.vbat_ov && vboff_q |=> stat_q[ST_VB_OV] && !lamp_q)
    else $error("battery overvoltage not handled");
  vs_uv_hold_a: assert property (stat_q[ST_VS_UV] && !frame_end |=> stat_q[ST_VS_UV])
    else $error("supply undervoltage latch lost before read");
  lin_fail_a: assert property (s.lin_txd_to |=> stat_q[ST_LIN])
    else $error("bus failure not reported");
  bus_wake_a: assert property ((s.lin_wake && csn) ##1 csn |=> !do_q && linw_q)
    else $error("bus wake not signalled");
  spi_fail_a: assert property (s.spi_fail && !csn |=> do_q)
    else $error("serial failure not driven high");
  vint_uv_a: assert property (s.vint_uv |=> !stat_q[ST_VINT] && !rout_q && !lamp_q
                              && mode_q == MD_STANDBY && !lp_en_q)
    else $error("internal undervoltage effects missing");
  wd_fail_a: assert property (wd_fail |=> !rout_q && wd_q == WD_LONG && stat_q[ST_WD]
                              && mode_q == MD_STANDBY)
    else $error("watchdog failure effects missing");
  service_a: assert property (sel_wd && wd_q == WD_OPEN && rout_q && !wd_off
                              |=> wd_q == WD_CLOSED && wcnt_q == '0)
    else $error("service did not restart closed window");
  other_write_a: assert property (sel_cfg && wd_q == WD_CLOSED && wcnt_q < half_q && !tick
                                  && rout_q && !wd_off |=> wd_q == WD_CLOSED)
    else $error("non-watchdog write disturbed window");
endmodule
`default_nettype wire
